// ==== src/lsd_top.sv ====
// Multiplexed segment display driver controller: timing, mapping and output control.
// Overview of operation
// - Four-bit contrast level, sixteen regulator settings.
// - Contrast ignored when regulator is off.
// - Block clock enable gates the operating clock.
// - Display state: off, normal, all-on, all-off.
// - Display off: no drive, outputs grounded.
// - All-on/all-off override waveform, RAM untouched.
// - Polarity zero inverts every segment on an enabled common.
// - No inversion in the all-off state.
// - Duty field selects one over value-plus-one.
// - Duty decides active commons and segments.
// - Disabled common shows off waveform.
// - Line count field sets AC inversion period.
// - RAM at 0x7000, one byte per column.
// - RAM one drives segment on, zero off.
// - RAM fully readable and writable by processor.
// - Unused RAM acts as ordinary memory.
// - Area select picks nibble at low duties.
// - Mapping depends on duty and directions.
// - Segment direction one ascends, zero descends.
// - Common direction one ascends, zero reverses.
// - Frame is 16*(count+1)*(duty+1) ticks.
// - Frame flag sets on switch, write-one clears.
`timescale 1ns/1ps
`default_nettype none
module lsd_top #(
  parameter int unsigned OP_DIV = lsd_pkg::OP_DIV
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic i_block_clock_enable,
  input wire logic [2:0] i_clock_divider_select,
  input wire logic [2:0] i_duty_select,
  input wire logic [3:0] i_frame_count,
  input wire logic [2:0] i_inverse_line_count,
  input wire logic i_regulator_enable,
  input wire logic [3:0] i_contrast_level,
  input wire logic [1:0] i_display_state_select,
  input wire logic i_display_polarity,
  input wire logic i_screen_area_select,
  input wire logic i_common_direction,
  input wire logic i_segment_direction,
  input wire logic [7:0] i_common_drive_enable,
  input wire logic i_frame_flag_clear,
  input wire logic i_frame_irq_enable,
  input wire logic i_ram_req,
  input wire logic i_ram_we,
  input wire logic [15:0] i_ram_addr,
  input wire logic [7:0] i_ram_wdata,
  output logic [7:0] o_ram_rdata,
  output logic o_drive_on,
  output logic o_ac_phase,
  output logic [7:0] o_common_outputs,
  output logic [31:0] o_segment_outputs,
  output logic o_frame_monitor_out,
  output logic o_frame_flag,
  output logic o_frame_irq,
  output logic [3:0] o_contrast_setting
);
  // Divider counter wide enough for the slowest divider setting.
  logic [19:0] div_cnt_q;
  logic [19:0] div_end;
  logic op_tick;
  // Line timing and scan position.
  logic [7:0] tick_cnt_q;
  logic [7:0] line_ticks;
  logic [2:0] line_q;
  logic line_end;
  logic frame_end;
  logic [2:0] nline_cnt_q;
  // Frame-held settings and the live settings they are taken from.
  lsd_pkg::lsd_cfg_s cfg_q;
  lsd_pkg::lsd_cfg_s cfg_live;
  // Scan engine.
  lsd_pkg::lsd_scan_e scan_q;
  logic [5:0] col_q;
  logic col_vld_q;
  logic [4:0] col_d1_q;
  logic [31:0] seg_acc_q;
  logic [7:0] scan_data;
  logic [5:0] seg_cnt;
  logic [2:0] bit_sel;
  logic [4:0] seg_pos;
  logic [2:0] com_pin;
  logic ram_hit;
  logic ram_we;

  // The operating tick period doubles with each divider select step.
  assign div_end = 20'(OP_DIV << i_clock_divider_select) - 20'h00001;
  assign op_tick = i_block_clock_enable && (div_cnt_q == div_end);

  // Operating clock divider; held cleared while the block clock is off.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      div_cnt_q <= 20'h00000;
    end
    else if (!i_block_clock_enable || op_tick)
    begin
      div_cnt_q <= 20'h00000;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 20'h00001;
    end
  end

  // A line lasts sixteen ticks per frame count step; a frame has duty+1 lines.
  assign line_ticks = 8'(lsd_pkg::LINE_TICK_UNIT * ({4'h0, i_frame_count} + 8'h01));
  assign line_end = op_tick && (tick_cnt_q >= line_ticks - 8'h01);
  assign frame_end = line_end && (line_q >= cfg_q.duty);

  // Line tick and line index counters.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      tick_cnt_q <= 8'h00;
      line_q <= 3'h0;
    end
    else if (!i_block_clock_enable)
    begin
      tick_cnt_q <= 8'h00;
      line_q <= 3'h0;
    end
    else if (line_end)
    begin
      tick_cnt_q <= 8'h00;
      line_q <= frame_end ? 3'h0 : line_q + 3'h1;
    end
    else if (op_tick)
    begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  // Gather the live settings into one carrier.
  always_comb
  begin
    cfg_live.state = i_display_state_select;
    cfg_live.polarity = i_display_polarity;
    cfg_live.area = i_screen_area_select;
    cfg_live.com_dir = i_common_direction;
    cfg_live.seg_dir = i_segment_direction;
    cfg_live.duty = i_duty_select;
    cfg_live.nline = i_inverse_line_count;
    cfg_live.com_en = i_common_drive_enable;
  end

  // Settings are taken at a frame switch, and every cycle while the block clock is off, so a panel never sees a half-changed frame.
  // The first frame after the block clock starts uses the settings then present.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      cfg_q <= '{state: lsd_pkg::DSP_OFF, polarity: 1'b1, area: 1'b0, com_dir: 1'b1,
                 seg_dir: 1'b1, duty: 3'h0, nline: 3'h0, com_en: lsd_pkg::COM_EN_RST};
    end
    else if (frame_end || !i_block_clock_enable)
    begin
      cfg_q <= cfg_live;
    end
  end

  // AC polarity toggles every frame, or every N lines when a line count is set.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      o_ac_phase <= 1'b0;
      nline_cnt_q <= 3'h0;
    end
    else if (!i_block_clock_enable)
    begin
      o_ac_phase <= 1'b0;
      nline_cnt_q <= 3'h0;
    end
    else if (cfg_q.nline == 3'h0)
    begin
      nline_cnt_q <= 3'h0;
      if (frame_end)
      begin
        o_ac_phase <= ~o_ac_phase;
      end
    end
    else if (line_end)
    begin
      // Inversion period counted in lines across frame switches.
      if (nline_cnt_q >= cfg_q.nline - 3'h1)
      begin
        nline_cnt_q <= 3'h0;
        o_ac_phase <= ~o_ac_phase;
      end
      else
      begin
        nline_cnt_q <= nline_cnt_q + 3'h1;
      end
    end
  end

  // Frame monitor toggles, and the sticky frame flag sets, at every frame switch.
  // A switch in the same cycle as a clear request keeps the flag set.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      o_frame_monitor_out <= 1'b0;
      o_frame_flag <= 1'b0;
    end
    else
    begin
      if (frame_end)
      begin
        o_frame_monitor_out <= ~o_frame_monitor_out;
      end
      if (frame_end)
      begin
        o_frame_flag <= 1'b1;
      end
      else if (i_frame_flag_clear)
      begin
        o_frame_flag <= 1'b0;
      end
    end
  end

  // Interrupt request follows the flag gated by its enable, one cycle later.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      o_frame_irq <= 1'b0;
    end
    else
    begin
      o_frame_irq <= o_frame_flag && i_frame_irq_enable;
    end
  end

  // Contrast reaches the regulator only while it runs; external supplies ignore it.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      o_contrast_setting <= 4'h0;
    end
    else
    begin
      o_contrast_setting <= i_regulator_enable ? i_contrast_level : 4'h0;
    end
  end

  // Processor writes are decoded against the RAM window; reads return the byte at the low five address bits for any address.
  assign ram_hit = i_ram_req && (i_ram_addr[15:5] == lsd_pkg::RAM_BASE[15:5]);
  assign ram_we = ram_hit && i_ram_we;

  // Display RAM: every byte is plain read/write memory whether scanned or not.
  lsd_ram #(
    .WORDS(lsd_pkg::RAM_WORDS),
    .AW(lsd_pkg::RAM_AW)
  ) u_ram (
    .i_clk(I_REF_CLK),
    .i_we(ram_we),
    .i_cpu_addr(i_ram_addr[4:0]),
    .i_cpu_wdata(i_ram_wdata),
    .o_cpu_rdata(o_ram_rdata),
    .i_scan_addr(col_q[4:0]),
    .o_scan_rdata(scan_data)
  );

  // Wide duties free the shared pins as commons and leave 28 segments.
  assign seg_cnt = (cfg_q.duty >= lsd_pkg::DUTY_WIDE_MIN) ?
                   lsd_pkg::SEG_CNT_WIDE : lsd_pkg::SEG_CNT_NARROW;
  // Line l reads bit l, moved to the high nibble for area 1 at low duties.
  assign bit_sel = ((cfg_q.duty < lsd_pkg::DUTY_WIDE_MIN) && cfg_q.area) ?
                   line_q + lsd_pkg::AREA1_BIT_OFS : line_q;
  // Column address to segment pin, ascending or descending.
  assign seg_pos = cfg_q.seg_dir ? col_d1_q : 5'(seg_cnt - 6'h01 - {1'b0, col_d1_q});
  // Line to common pin, ascending or reversed across the active commons.
  assign com_pin = cfg_q.com_dir ? line_q : cfg_q.duty - line_q;

  // Scan engine: at each line start, and again at the first tick of line 0, read every active column.
  // Reading takes about 30 reference cycles, far below one operating tick.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      scan_q <= lsd_pkg::SCAN_IDLE;
      col_q <= 6'h00;
      col_vld_q <= 1'b0;
      col_d1_q <= 5'h00;
    end
    else
    begin
      col_vld_q <= (scan_q == lsd_pkg::SCAN_FETCH) && (col_q < seg_cnt);
      col_d1_q <= col_q[4:0];
      case (scan_q)
        lsd_pkg::SCAN_IDLE:
        begin
          col_q <= 6'h00;
          if (line_end || (op_tick && tick_cnt_q == 8'h00 && line_q == 3'h0))
          begin
            scan_q <= lsd_pkg::SCAN_FETCH;
          end
        end
        lsd_pkg::SCAN_FETCH:
        begin
          if (col_q >= seg_cnt)
          begin
            scan_q <= lsd_pkg::SCAN_IDLE;
          end
          else
          begin
            col_q <= col_q + 6'h01;
          end
        end
        default:
        begin
          scan_q <= lsd_pkg::SCAN_IDLE;
        end
      endcase
    end
  end

  // Collect the selected bit of each column; unused pins stay off.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      seg_acc_q <= 32'h00000000;
    end
    else if (scan_q == lsd_pkg::SCAN_IDLE && col_q == 6'h00 && !col_vld_q)
    begin
      seg_acc_q <= 32'h00000000;
    end
    else if (col_vld_q)
    begin
      seg_acc_q[seg_pos] <= scan_data[bit_sel];
    end
  end

  // Output stage: update pins once the line's columns are all gathered.
  // The scan drops to idle one cycle after its last fetch, with the column counter
  // still parked at the end; that single cycle is when the last column has landed.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      o_drive_on <= 1'b0;
      o_common_outputs <= 8'h00;
      o_segment_outputs <= 32'h00000000;
    end
    else if (!i_block_clock_enable || cfg_q.state == lsd_pkg::DSP_OFF)
    begin
      // No drive voltage and every driver pin at ground.
      o_drive_on <= 1'b0;
      o_common_outputs <= 8'h00;
      o_segment_outputs <= 32'h00000000;
    end
    else if (cfg_q.state == lsd_pkg::DSP_ALL_OFF)
    begin
      // Static common drive with every segment off; polarity has no effect here.
      o_drive_on <= 1'b1;
      o_common_outputs <= 8'h00;
      o_segment_outputs <= 32'h00000000;
    end
    else if (scan_q == lsd_pkg::SCAN_IDLE && col_q >= seg_cnt)
    begin
      o_drive_on <= 1'b1;
      o_common_outputs <= 8'h01 << com_pin;
      if (!cfg_q.com_en[com_pin])
      begin
        // A disabled common shows the off waveform whatever RAM holds.
        o_segment_outputs <= 32'h00000000;
      end
      else if (cfg_q.state == lsd_pkg::DSP_ALL_ON)
      begin
        // Dynamic commons with every active segment forced on, RAM untouched.
        o_segment_outputs <= (cfg_q.polarity ? 32'hFFFFFFFF : 32'h00000000) >>
                             (6'h20 - seg_cnt);
      end
      else
      begin
        o_segment_outputs <= (cfg_q.polarity ? seg_acc_q : ~seg_acc_q) &
                             (32'hFFFFFFFF >> (6'h20 - seg_cnt));
      end
    end
  end
endmodule // lsd_top
`default_nettype wire

// ==== src/lsd_pkg.sv ====
// Shared constants and types for the segment display driver controller.
package lsd_pkg;
  // Reference clock and nominal driver operating clock rates.
  localparam int unsigned REF_CLK_HZ = 50_000_000;
  localparam int unsigned OP_CLK_HZ = 32_768;
  // Reference cycles per operating clock tick, rounded to nearest.
  localparam int unsigned OP_DIV = (REF_CLK_HZ + OP_CLK_HZ / 2) / OP_CLK_HZ;
  // Display RAM placement and size.
  localparam logic [15:0] RAM_BASE = 16'h7000;
  localparam int unsigned RAM_WORDS = 32;
  localparam int unsigned RAM_AW = 5;
  // Operating clock ticks per line for each frame count step.
  localparam logic [7:0] LINE_TICK_UNIT = 8'h10;
  // Duty codes at which the shared pins become commons.
  localparam logic [2:0] DUTY_WIDE_MIN = 3'h4;
  // Active segment counts for wide and narrow common sets.
  localparam logic [5:0] SEG_CNT_WIDE = 6'h1C;
  localparam logic [5:0] SEG_CNT_NARROW = 6'h20;
  // Upper nibble offset used by screen area 1.
  localparam logic [2:0] AREA1_BIT_OFS = 3'h4;
  // Display state codes.
  localparam logic [1:0] DSP_OFF = 2'h0;
  localparam logic [1:0] DSP_NORMAL = 2'h1;
  localparam logic [1:0] DSP_ALL_ON = 2'h2;
  localparam logic [1:0] DSP_ALL_OFF = 2'h3;
  // Reset value of the shadowed common drive enables.
  localparam logic [7:0] COM_EN_RST = 8'h00;

  // Display settings held for one whole frame.
  typedef struct packed {
    logic [1:0] state;
    logic polarity;
    logic area;
    logic com_dir;
    logic seg_dir;
    logic [2:0] duty;
    logic [2:0] nline;
    logic [7:0] com_en;
  } lsd_cfg_s;

  // Scan engine states.
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_FETCH = 2'b10
  } lsd_scan_e;
endpackage

// ==== src/lsd_ram.sv ====
// Display data RAM with a processor port and a scan read port.
`timescale 1ns/1ps
`default_nettype none
module lsd_ram #(
  parameter int unsigned WORDS = 32,
  parameter int unsigned AW = 5
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  input wire logic [AW-1:0] i_scan_addr,
  output logic [7:0] o_scan_rdata
);
  // Storage; contents are undefined after power-up like any RAM.
  logic [7:0] mem_q [WORDS];

  // Processor write and registered reads on both ports.
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_q[i_cpu_addr] <= i_cpu_wdata;
    end
    o_cpu_rdata <= mem_q[i_cpu_addr];
    o_scan_rdata <= mem_q[i_scan_addr];
  end
endmodule // lsd_ram
`default_nettype wire

// ==== tb/lsd_top_sva.sv ====
// Port-level checker for the segment display controller.
`timescale 1ns/1ps
`default_nettype none
module lsd_top_sva (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic i_block_clock_enable,
  input wire logic i_regulator_enable,
  input wire logic [3:0] i_contrast_level,
  input wire logic [1:0] i_display_state_select,
  input wire logic i_frame_flag_clear,
  input wire logic i_frame_irq_enable,
  input wire logic i_ram_req,
  input wire logic i_ram_we,
  input wire logic [15:0] i_ram_addr,
  input wire logic [7:0] i_ram_wdata,
  input wire logic [7:0] o_ram_rdata,
  input wire logic o_drive_on,
  input wire logic [7:0] o_common_outputs,
  input wire logic [31:0] o_segment_outputs,
  input wire logic o_frame_monitor_out,
  input wire logic o_frame_flag,
  input wire logic o_frame_irq,
  input wire logic [3:0] o_contrast_setting
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  // True while no driver pin carries anything and the supply is off.
  wire logic pins_zero = (o_common_outputs == 8'h00) && (o_segment_outputs == 32'h0) && !o_drive_on;

  a_clk_off_ground: assert property (
    (!i_block_clock_enable)[*3] |-> pins_zero) else $error("pins live without clock");
  // Display off is taken at a frame switch, so the grounding follows the switch that took it.
  a_off_ground: assert property (
    $changed(o_frame_monitor_out) && ($past(i_display_state_select) == lsd_pkg::DSP_OFF) |=>
    pins_zero) else $error("pins live when off");
  a_contrast_follows: assert property (
    $past(I_NRST) && $stable(i_regulator_enable) && $stable(i_contrast_level) |=>
    o_contrast_setting == ($past(i_regulator_enable) ? $past(i_contrast_level) : 4'h0))
    else $error("contrast setting wrong");
  a_irq_follows: assert property (
    o_frame_irq == $past(o_frame_flag && i_frame_irq_enable)) else $error("irq wrong");
  a_flag_on_switch: assert property (
    $changed(o_frame_monitor_out) |-> o_frame_flag) else $error("flag missed switch");
  a_flag_sticky: assert property (
    o_frame_flag && !i_frame_flag_clear |=> o_frame_flag) else $error("flag dropped");
  a_flag_clear: assert property (
    i_frame_flag_clear ##1 !$changed(o_frame_monitor_out) |-> !o_frame_flag)
    else $error("flag not cleared");
  a_com_onehot: assert property (
    $onehot0(o_common_outputs)) else $error("several commons selected");
  a_shared_pins: assert property (
    |o_common_outputs[7:4] |-> o_segment_outputs[31:28] == 4'h0) else $error("shared pin clash");
  a_ram_rdwr: assert property (
    i_ram_req && i_ram_we && (i_ram_addr[15:5] == lsd_pkg::RAM_BASE[15:5]) ##1
    (i_ram_addr == $past(i_ram_addr)) && !(i_ram_req && i_ram_we) |=>
    o_ram_rdata == $past(i_ram_wdata, 2)) else $error("ram readback wrong");

  c_irq: cover property ($rose(o_frame_irq));
  c_lit: cover property (o_drive_on && |o_segment_outputs);
  c_clear: cover property (i_frame_flag_clear && o_frame_flag);
endmodule // lsd_top_sva
bind lsd_top lsd_top_sva i_sva (.*);
`default_nettype wire

// ==== tb/lsd_panel_model.sv ====
// Passive panel model that remembers the pattern shown under each common.
`timescale 1ns/1ps
`default_nettype none
module lsd_panel_model (
  input wire logic i_clk,
  input wire logic i_drive_on,
  input wire logic [7:0] i_com,
  input wire logic [31:0] i_seg,
  output logic [7:0][31:0] o_row
);
  // A row only changes while its common is selected with supply on.
  always_ff @(posedge i_clk)
  begin
    for (int c = 0; c < 8; c++)
    begin
      if (i_drive_on && i_com[c])
      begin
        o_row[c] <= i_seg;
      end
    end
  end
endmodule // lsd_panel_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the segment display controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic I_REF_CLK = 1'b0;
  logic I_NRST = 1'b0;
  logic i_block_clock_enable = 1'b0;
  logic [2:0] i_clock_divider_select = 3'h0;
  logic [3:0] i_frame_count = 4'h0;
  logic i_regulator_enable = 1'b1;
  logic [3:0] i_contrast_level = 4'h0;
  logic i_frame_flag_clear = 1'b0;
  logic i_frame_irq_enable = 1'b0;
  logic i_ram_req = 1'b0;
  logic i_ram_we = 1'b0;
  logic [15:0] i_ram_addr = 16'h7000;
  logic [7:0] i_ram_wdata = 8'h00;
  // Frame-aligned settings are driven from one struct.
  lsd_pkg::lsd_cfg_s cfg = '{2'h1, 1'b1, 1'b0, 1'b1, 1'b1, 3'h7, 3'h0, 8'hFF};
  wire logic [2:0] i_duty_select = cfg.duty;
  wire logic [2:0] i_inverse_line_count = cfg.nline;
  wire logic [1:0] i_display_state_select = cfg.state;
  wire logic i_display_polarity = cfg.polarity;
  wire logic i_screen_area_select = cfg.area;
  wire logic i_common_direction = cfg.com_dir;
  wire logic i_segment_direction = cfg.seg_dir;
  wire logic [7:0] i_common_drive_enable = cfg.com_en;
  wire logic [7:0] o_ram_rdata;
  wire logic o_drive_on;
  wire logic o_ac_phase;
  wire logic [7:0] o_common_outputs;
  wire logic [31:0] o_segment_outputs;
  wire logic o_frame_monitor_out;
  wire logic o_frame_flag;
  wire logic o_frame_irq;
  wire logic [3:0] o_contrast_setting;
  wire logic [7:0][31:0] row;
  logic [7:0] mem [32];
  logic [7:0] d;
  int err_total = 0;
  int total_checks = 0;
  int n;
  int ac;

  always #10 I_REF_CLK = ~I_REF_CLK;

  // A small divider keeps frames short; every figure below scales with it.
  lsd_top #(.OP_DIV(4)) i_dut (.*);
  lsd_panel_model i_panel (.i_clk(I_REF_CLK), .i_drive_on(o_drive_on),
    .i_com(o_common_outputs), .i_seg(o_segment_outputs), .o_row(row));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One RAM cycle; the request stays up so back-to-back calls never toggle it.
  task automatic ram(input logic we, input logic [15:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    i_ram_req = 1'b1;
    i_ram_we = we;
    i_ram_addr = a;
    i_ram_wdata = wd;
    @(negedge I_REF_CLK);
    rd = o_ram_rdata;
  endtask

  // Waits for the next frame switch, counting cycles and AC flips meanwhile.
  task automatic wait_frame();
    logic m;
    logic a;
    m = o_frame_monitor_out;
    a = o_ac_phase;
    n = 0;
    ac = 0;
    while (o_frame_monitor_out === m)
    begin
      @(posedge I_REF_CLK);
      #1;
      n++;
      ac += (o_ac_phase !== a) ? 1 : 0;
      a = o_ac_phase;
      if (n > 10000)
      begin
        err_total++;
        final_report();
      end
    end
    @(negedge I_REF_CLK);
  endtask

  task automatic period(input logic [2:0] du, input logic [3:0] fc, input logic [2:0] sel);
    cfg.duty = du;
    i_frame_count = fc;
    i_clock_divider_select = sel;
    wait_frame();
    wait_frame();
    chk("frame period", n, 16 * (fc + 1) * (du + 1) * (4 << sel));
  endtask

  // Expected pattern under common c for the current settings and RAM image.
  function automatic logic [31:0] exp_row(input int c);
    int nseg;
    int col;
    int b;
    logic [31:0] r;
    r = '0;
    nseg = (cfg.duty >= 3'h4) ? 28 : 32;
    b = cfg.com_dir ? c : int'(cfg.duty) - c;
    b = b + ((cfg.duty < 3'h4 && cfg.area) ? 4 : 0);
    for (int s = 0; s < nseg; s++)
    begin
      col = cfg.seg_dir ? s : nseg - 1 - s;
      r[s] = (cfg.state == lsd_pkg::DSP_ALL_ON) | mem[col][b];
      r[s] = r[s] ^ !cfg.polarity;
    end
    return cfg.com_en[c] ? r : 32'h0;
  endfunction

  task automatic image(input string what);
    wait_frame();
    wait_frame();
    for (int c = 0; c <= int'(cfg.duty); c++)
    begin
      chk(what, row[c], exp_row(c));
    end
  endtask

  initial
  begin
    repeat (2) @(negedge I_REF_CLK);
    I_NRST = 1'b1;
    @(negedge I_REF_CLK);
    chk("idle pins", {o_drive_on, o_common_outputs, o_segment_outputs}, '0);
    for (int a = 0; a < 32; a++)
    begin
      mem[a] = 8'(a * 8'h25 + 8'h0B);
      ram(1'b1, 16'h7000 + 16'(a), mem[a], d);
      ram(1'b0, 16'h7000 + 16'(a), 8'h00, d);
      chk("ram write read", d, mem[a]);
    end
    // Just past the window: must not land on the first byte.
    ram(1'b1, 16'h7020, 8'h5A, d);
    for (int a = 0; a < 32; a++)
    begin
      ram(1'b0, 16'h7000 + 16'(a), 8'h00, d);
      chk("ram keep", d, mem[a]);
    end
    i_ram_req = 1'b0;
    i_block_clock_enable = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      period(3'(k), 4'(k), 3'(k % 2));
    end
    i_frame_count = 4'h0;
    i_clock_divider_select = 3'h0;
    cfg.duty = 3'h7;
    for (int k = 0; k < 4; k++)
    begin
      cfg.nline = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
      wait_frame();
      wait_frame();
      chk("ac flips", ac, (k == 0) ? 1 : 8 >> (k - 1));
    end
    cfg.nline = 3'h0;
    image("normal view");
    cfg.seg_dir = 1'b0;
    image("segments reversed");
    cfg.com_dir = 1'b0;
    cfg.polarity = 1'b0;
    image("inverted");
    cfg.com_en = 8'h5E;
    image("blanked commons");
    cfg.state = lsd_pkg::DSP_ALL_ON;
    cfg.polarity = 1'b1;
    image("all on");
    cfg = '{2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 3'h3, 3'h0, 8'hFF};
    image("area one");
    cfg.duty = 3'h0;
    cfg.area = 1'b0;
    image("static");
    cfg.state = lsd_pkg::DSP_ALL_OFF;
    cfg.polarity = 1'b0;
    wait_frame();
    wait_frame();
    chk("all off pins", {o_common_outputs, o_segment_outputs}, '0);
    ram(1'b0, 16'h7007, 8'h00, d);
    chk("ram untouched", d, mem[7]);
    i_ram_req = 1'b0;
    for (int l = 0; l < 16; l++)
    begin
      i_contrast_level = 4'(l);
      @(negedge I_REF_CLK);
      chk("contrast", o_contrast_setting, l);
    end
    i_regulator_enable = 1'b0;
    repeat (2) @(negedge I_REF_CLK);
    chk("contrast external", o_contrast_setting, 0);
    // Back to internal generation so the power-down below starts from it.
    i_regulator_enable = 1'b1;
    cfg.state = lsd_pkg::DSP_NORMAL;
    i_frame_irq_enable = 1'b1;
    wait_frame();
    @(negedge I_REF_CLK);
    chk("flag and irq", {o_frame_flag, o_frame_irq}, 2'h3);
    i_frame_flag_clear = 1'b1;
    @(negedge I_REF_CLK);
    i_frame_flag_clear = 1'b0;
    @(negedge I_REF_CLK);
    chk("flag cleared", {o_frame_flag, o_frame_irq}, 2'h0);
    i_frame_irq_enable = 1'b0;
    wait_frame();
    @(negedge I_REF_CLK);
    chk("irq masked", {o_frame_flag, o_frame_irq}, 2'h2);
    // Power-down: display off first, taken at the next frame switch.
    cfg.state = lsd_pkg::DSP_OFF;
    wait_frame();
    repeat (2) @(negedge I_REF_CLK);
    chk("off pins", {o_drive_on, o_common_outputs, o_segment_outputs}, '0);
    i_regulator_enable = 1'b0;
    i_block_clock_enable = 1'b0;
    repeat (3) @(negedge I_REF_CLK);
    chk("clock off pins", {o_drive_on, o_common_outputs, o_segment_outputs}, '0);
    // Power-up runs the same steps backwards, the display coming back last.
    i_block_clock_enable = 1'b1;
    i_regulator_enable = 1'b1;
    repeat (2) @(negedge I_REF_CLK);
    cfg.state = lsd_pkg::DSP_NORMAL;
    image("power up");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
